// ===== src/cpia_pkg.sv
// Notes on behaviour
// - program flash guard is config bit 0, low means guarded.
// - eeprom guard is config bit 1, low means guarded.
// - config bits 13..2 always read back as ones.
// - blank config word reads all ones, so nothing is guarded.
// - flash and eeprom gating are independent, each by its own flag.
// - flash guarded: external writes dropped, external reads return zeros.
// - cpu fetches and reads of flash always pass.
// - eeprom guarded: external writes dropped, external reads return zeros.
// - cpu reads and writes eeprom whatever the guard flags.
// - cpu self-writes to flash follow only the range select field.
// - four user id words 8000h..8003h are read and writable.
// - 14-bit part identifier word reads at 8006h.
// - 14-bit silicon step word reads at 8005h.
// - id and revision words ignore all erase and write attempts.
// - silicon step bits 13..12 always read binary 10.
// - range 11 none, 10 guards 0-1ffh, 01 guards 0-fffh, 00 guards 0-1fffh.
// - range select never blocks writes from the external programming port.
package cpia_pkg;

  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int unsigned WORD_W = 14;
  localparam int unsigned GUARD_FLASH_BIT = 0;
  localparam int unsigned GUARD_EE_BIT = 1;
  localparam logic [13:0] CFG_BLANK = 14'h3fff;
  localparam logic [1:0] STEP_TOP = 2'h2;
  localparam int unsigned NVM_ADDR_W = 16;

  // ------------------------------------------------------------
  // nvm address map
  // ------------------------------------------------------------
  localparam logic [15:0] UID_BASE = 16'h8000;
  localparam logic [15:0] UID_LAST = 16'h8003;
  localparam logic [15:0] STEP_ADDR = 16'h8005;
  localparam logic [15:0] PART_ADDR = 16'h8006;
  localparam logic [15:0] LIM_BOOT = 16'h01ff;
  localparam logic [15:0] LIM_HALF = 16'h0fff;
  localparam logic [15:0] LIM_ALL = 16'h1fff;
  localparam logic [1:0] RANGE_OFF = 2'h3;
  localparam logic [1:0] RANGE_BOOT = 2'h2;
  localparam logic [1:0] RANGE_HALF = 2'h1;
  localparam logic [1:0] RANGE_ALL = 2'h0;

  // ------------------------------------------------------------
  // ahb register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_RANGE = 8'h04;
  localparam logic [7:0] OFF_STEP = 8'h08;
  localparam logic [7:0] OFF_PART = 8'h0c;
  localparam logic [7:0] OFF_UID0 = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    CPIA_MEM_FLASH,
    CPIA_MEM_EE,
    CPIA_MEM_CFG
  } cpia_mem_t;

  typedef struct packed {
    logic valid;
    logic external;
    logic write;
    cpia_mem_t mem;
    logic [15:0] addr;
    logic [13:0] wdata;
  } cpia_req_t;

  typedef struct packed {
    logic allow;
    logic zero_data;
  } cpia_gate_t;

endpackage

// ===== src/cpia_top.sv
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cpia_top
  import cpia_pkg::*;
#(
  parameter logic [13:0] PART_ID = 14'h0123, // arbitrary value
  parameter logic [11:0] STEP_LOW = 12'h001, // arbitrary value
  parameter int unsigned UID_N = 4
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // nonvolatile config bits, latched on the first enabled clock after reset
  input wire logic [1:0] nv_guard_bits,
  input wire logic [1:0] nv_range_sel,
  // memory access request
  input wire cpia_req_t req,
  output cpia_gate_t gate,
  // nvm read data in and filtered data out
  input wire logic [13:0] mem_rdata,
  output logic [13:0] rdata_out,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ------------------------------------------------------------
  // latched config
  // ------------------------------------------------------------
  logic latched_reg, latched_next;
  logic [1:0] guard_reg, guard_next;
  logic [1:0] range_reg, range_next;

  always_comb begin
    latched_next = latched_reg;
    guard_next = guard_reg;
    range_next = range_reg;
    if (!latched_reg) begin
      latched_next = 1'b1;
      guard_next = nv_guard_bits;
      range_next = nv_range_sel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched_reg <= 1'b0;
      guard_reg <= CFG_BLANK[1:0];
      range_reg <= RANGE_OFF;
    end else if (clk_en) begin
      latched_reg <= latched_next;
      guard_reg <= guard_next;
      range_reg <= range_next;
    end
  end

  logic flash_guard_n, eeprom_guard_n;
  assign flash_guard_n = guard_reg[GUARD_FLASH_BIT];
  assign eeprom_guard_n = guard_reg[GUARD_EE_BIT];

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic range_blocks(input logic [1:0] sel, input logic [15:0] a);
    logic r;
    r = 1'b0;
    unique case (sel)
      RANGE_OFF: r = 1'b0;
      RANGE_BOOT: r = (a <= LIM_BOOT);
      RANGE_HALF: r = (a <= LIM_HALF);
      RANGE_ALL: r = (a <= LIM_ALL);
    endcase
    return r;
  endfunction

  function automatic logic is_fixed_id(input logic [15:0] a);
    return (a == STEP_ADDR) || (a == PART_ADDR);
  endfunction

  // bus uid slot decode, shared by the bus write and the bus read; the req port uses cfg_uid_hit
  function automatic logic bus_uid_hit(input logic [7:0] a, input int slot);
    return a == OFF_UID0 + 8'(slot * 4);
  endfunction

  function automatic logic cfg_uid_hit(input logic [15:0] a, input int slot);
    return (a == UID_BASE + 16'(slot)) && (a <= UID_LAST);
  endfunction

  logic [13:0] step_word, part_word, cfg_word;
  assign step_word = {STEP_TOP, STEP_LOW};
  assign part_word = PART_ID;
  assign cfg_word = {CFG_BLANK[13:2], guard_reg};

  // ------------------------------------------------------------
  // access gating
  // ------------------------------------------------------------
  logic self_write_range_sel_hit;
  assign self_write_range_sel_hit = range_blocks(range_reg, req.addr);

  always_comb begin
    gate.allow = 1'b0;
    gate.zero_data = 1'b0;
    if (req.valid) begin
      gate.allow = 1'b1;
      unique case (req.mem)
        CPIA_MEM_FLASH: begin
          if (req.external) begin
            // each memory sees only its own flag
            gate.allow = flash_guard_n;
            gate.zero_data = !flash_guard_n && !req.write;
            // range select not consulted on the programming port
          end else if (req.write) begin
            gate.allow = !self_write_range_sel_hit;
          end else begin
            gate.allow = 1'b1;
          end
        end
        CPIA_MEM_EE: begin
          if (req.external) begin
            gate.allow = eeprom_guard_n;
            gate.zero_data = !eeprom_guard_n && !req.write;
          end else begin
            gate.allow = 1'b1;
          end
        end
        CPIA_MEM_CFG: begin
          // fixed words are mask rom, writes and erases never reach them
          if (req.write && is_fixed_id(req.addr)) begin
            gate.allow = 1'b0;
          end else begin
            gate.allow = 1'b1;
          end
        end
        default: gate.allow = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read data path
  // ------------------------------------------------------------
  logic [13:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (req.valid && !req.write) begin
      rdata_next = mem_rdata;
      if (gate.zero_data) begin
        rdata_next = '0;
      end else if (req.mem == CPIA_MEM_CFG) begin
        if (req.addr == STEP_ADDR) begin
          rdata_next = step_word;
        end else if (req.addr == PART_ADDR) begin
          rdata_next = part_word;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= '0;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // user id words, cpu side copy
  // ------------------------------------------------------------
  logic [13:0] uid_reg [UID_N];
  logic [13:0] uid_next [UID_N];
  logic bus_wr_reg, bus_wr_next;
  logic [7:0] bus_addr_reg, bus_addr_next;

  genvar gi;
  generate
    for (gi = 0; gi < UID_N; gi++) begin : g_uid
      always_comb begin
        uid_next[gi] = uid_reg[gi];
        if (bus_wr_reg && bus_uid_hit(bus_addr_reg, gi)) begin
          uid_next[gi] = hwdata[13:0];
        end else if (req.valid && req.write && req.mem == CPIA_MEM_CFG
                     && cfg_uid_hit(req.addr, gi)) begin
          uid_next[gi] = req.wdata;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          uid_reg[gi] <= CFG_BLANK;
        end else if (clk_en) begin
          uid_reg[gi] <= uid_next[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  logic take;
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

  // register read mux, evaluated in the address phase
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      OFF_CFG: begin
        v = {18'h0, cfg_word};
      end
      OFF_RANGE: begin
        v = {30'h0, range_reg};
      end
      OFF_STEP: begin
        v = {18'h0, step_word};
      end
      OFF_PART: begin
        v = {18'h0, part_word};
      end
      OFF_STAT: begin
        v = {29'h0, gate.zero_data, gate.allow, latched_reg};
      end
      default: begin
        for (int i = 0; i < UID_N; i++) begin
          if (bus_uid_hit(a, i)) begin
            v = {18'h0, uid_reg[i]};
          end
        end
      end
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------
  // ahb data phase tracking
  // ------------------------------------------------------------
  // hwdata lags its address by one cycle, so the address is held here
  always_comb begin
    bus_wr_next = take && hwrite; // only uid words accept writes
    bus_addr_next = bus_addr_reg;
    if (take) begin
      bus_addr_next = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= '0;
    end else if (clk_en) begin
      bus_wr_reg <= bus_wr_next;
      bus_addr_reg <= bus_addr_next;
    end
  end

  // ------------------------------------------------------------
  // ahb read data
  // ------------------------------------------------------------
  // registered so hrdata stands through the data phase and after it
  logic [31:0] hrdata_reg, hrdata_next;

  always_comb begin
    hrdata_next = hrdata_reg;
    if (take && !hwrite) begin
      hrdata_next = reg_read(haddr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (clk_en) begin
      hrdata_reg <= hrdata_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata_out = rdata_reg;
  assign hrdata = hrdata_reg;
  // no wait states and no error responses, so both stay constant
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// ===== bench/cpia_props.sv
`timescale 1ns/1ps
module cpia_props
  import cpia_pkg::*;
(
  // clock and config pins
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [1:0] nv_guard_bits,
  input wire logic [1:0] nv_range_sel,
  // access port and bus
  input wire cpia_req_t req,
  input wire cpia_gate_t gate,
  input wire logic [13:0] mem_rdata,
  input wire logic [13:0] rdata_out,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // ----------------
  // shadow of config
  // ----------------
  logic [1:0] g_reg;
  logic [1:0] r_reg;
  logic lat_reg;
  logic fl;
  logic rd;
  logic tk;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // pins are only trusted once latched, so every gate check waits for it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_reg <= 1'b0;
    end else if (clk_en && !lat_reg) begin
      lat_reg <= 1'b1;
      g_reg <= nv_guard_bits;
      r_reg <= nv_range_sel;
    end
  end
  assign fl = lat_reg && req.valid && req.mem == CPIA_MEM_FLASH;
  assign rd = lat_reg && req.valid && !req.write && clk_en && req.mem != CPIA_MEM_CFG;
  assign tk = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && clk_en;
  a_flash_ext_guard: assert property (fl && req.external && !g_reg[0] |-> !gate.allow)
    else $error("flash ext passed");
  a_ext_no_range: assert property (fl && req.external && g_reg[0] |-> gate.allow)
    else $error("flash ext refused");
  a_ee_ext_guard: assert property (lat_reg && req.valid && req.external && req.mem == CPIA_MEM_EE
    && !g_reg[1] |-> !gate.allow) else $error("ee ext passed");
  a_cpu_ee_free: assert property (lat_reg && req.valid && !req.external && req.mem == CPIA_MEM_EE
    |-> gate.allow) else $error("cpu ee refused");
  a_cpu_flash_rd: assert property (fl && !req.external && !req.write |-> gate.allow)
    else $error("cpu read refused");
  a_self_range: assert property (fl && !req.external && req.write |-> gate.allow == (r_reg == RANGE_OFF
    || req.addr > (r_reg == RANGE_BOOT ? LIM_BOOT : r_reg == RANGE_HALF ? LIM_HALF : LIM_ALL)))
    else $error("self write range");
  a_zero_rdata: assert property (rd && gate.zero_data |=> rdata_out == 14'h0)
    else $error("guarded data leaked");
  a_pass_rdata: assert property (rd && !gate.zero_data |=> rdata_out == $past(mem_rdata))
    else $error("read data altered");
  a_cfg_read: assert property (tk && lat_reg && haddr == OFF_CFG |=> hrdata[13:0] == {12'hfff, g_reg})
    else $error("config word");
  a_step_top: assert property (tk && haddr == OFF_STEP |=> hrdata[13:12] == STEP_TOP)
    else $error("step top bits");
endmodule

// ===== bench/cpia_nvm_model.sv
`timescale 1ns/1ps
module cpia_nvm_model
  import cpia_pkg::*;
(
  // request and raw array data
  input wire logic hclk,
  input wire cpia_req_t req,
  output logic [13:0] mem_rdata
);
  logic [13:0] last_reg;
  // released lines flip so a stale value can never pass as fresh
  always_ff @(posedge hclk) last_reg <= mem_rdata;
  always_comb begin
    if (req.valid && !req.write) begin
      mem_rdata = req.addr[13:0] ^ 14'h2a5;
    end else begin
      mem_rdata = ~last_reg;
    end
  end
endmodule

// ===== bench/test_code_protect_and_id_access.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin failures++; $display("wrong value %s exp %h got %h", n, e, s); end end
module test_code_protect_and_id_access
  import cpia_pkg::*;
;
  // -----------
  // bench state
  // -----------
  logic hclk = 1'b0;
  logic hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [1:0] nv_guard_bits, nv_range_sel, htrans, gd, rg;
  logic [2:0] hsize;
  logic [7:0] haddr;
  logic [13:0] mem_rdata, rdata_out;
  logic [31:0] hwdata, hrdata, rv;
  cpia_req_t req;
  cpia_gate_t gate;
  int failures, tests_run, cyc, seed;
  int lims[4] = '{8191, 4095, 511, 0};
  always #10 hclk = ~hclk;
  // part and step values are arbitrary
  cpia_top #(.PART_ID(14'h0a5c), .STEP_LOW(12'h3c1)) dut (.hclk, .hresetn, .clk_en, .nv_guard_bits, .nv_range_sel,
    .req, .gate, .mem_rdata, .rdata_out, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp);
  cpia_nvm_model nvm (.hclk, .req, .mem_rdata);
  task conclude;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task rst(input logic [1:0] g, input logic [1:0] r);
    hresetn <= 1'b0;
    nv_guard_bits <= g;
    nv_range_sel <= r;
    gd = g;
    rg = r;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  // model: external side sees only its guard, the cpu only the write range
  task rq(input logic e, input logic w, input cpia_mem_t m, input logic [15:0] a, input logic [13:0] d);
    int ok;
    int z;
    @(posedge hclk);
    req <= {1'b1, e, w, m, a, d};
    ok = (m == CPIA_MEM_FLASH) ? (e ? gd[0] : (!w || rg == 2'h3 || a > lims[rg])) : (e ? gd[1] : 1);
    z = e && !w && !ok;
    @(negedge hclk);
    `CHK("allow", ok[0], gate.allow)
    if (!w) `CHK("zero", z[0], gate.zero_data)
    @(posedge hclk);
    req.valid <= 1'b0;
    @(negedge hclk);
    if (!w) `CHK("rdata", z ? 14'h0 : a[13:0] ^ 14'h2a5, rdata_out)
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    seed = 11689;
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    clk_en = 1'b1;
    req = '0;
    for (int k = 0; k < 4; k++) begin
      rst(k[1:0], 2'(3 - k));
      ahb(0, OFF_CFG, 0); `CHK("cfg", {12'hfff, gd}, rv[13:0])
      ahb(0, OFF_RANGE, 0); `CHK("range", rg, rv[1:0])
      ahb(0, OFF_STEP, 0); `CHK("step", {STEP_TOP, 12'h3c1}, rv[13:0])
      ahb(0, OFF_PART, 0); `CHK("part", 14'h0a5c, rv[13:0])
      ahb(0, OFF_STAT, 0); `CHK("stat", 32'h1, rv)
      if (rg != 2'h3) begin
        rq(0, 1, CPIA_MEM_FLASH, 16'(lims[rg]), 14'h1);
        if (rg != 2'h0) rq(0, 1, CPIA_MEM_FLASH, 16'(lims[rg] + 1), 14'h1);
      end
      for (int i = 0; i < 16; i++) begin
        rv = $random(seed);
        rq(rv[0], rv[1], cpia_mem_t'({1'b0, rv[2]}), rv[2] ? {8'h0, rv[15:8]} : {3'h0, rv[28:16]}, rv[29:16]);
      end
      nv_guard_bits <= ~gd;
      ahb(0, OFF_CFG, 0); `CHK("held", {12'hfff, gd}, rv[13:0])
    end
    for (int i = 0; i < 4; i++) begin
      ahb(1, 8'(OFF_UID0 + 4 * i), 32'h1230 + i);
      ahb(0, 8'(OFF_UID0 + 4 * i), 0); `CHK("uid", 14'h1230 + i, rv[13:0])
    end
    clk_en <= 1'b0;
    ahb(1, OFF_UID0, 32'h3);
    clk_en <= 1'b1;
    ahb(0, OFF_UID0, 0); `CHK("frozen", 14'h1230, rv[13:0])
    ahb(1, OFF_STEP, 0);
    ahb(1, OFF_PART, 0);
    ahb(0, OFF_STEP, 0); `CHK("step wr", {STEP_TOP, 12'h3c1}, rv[13:0])
    ahb(0, OFF_PART, 0); `CHK("part wr", 14'h0a5c, rv[13:0])
    ahb(0, 8'h40, 0); `CHK("unmapped", 32'h0, rv)
    @(posedge hclk);
    req <= {1'b1, 1'b0, 1'b0, CPIA_MEM_CFG, STEP_ADDR, 14'h0};
    @(posedge hclk);
    req.addr <= PART_ADDR;
    @(negedge hclk);
    `CHK("step rd", {STEP_TOP, 12'h3c1}, rdata_out)
    @(posedge hclk);
    req.valid <= 1'b0;
    @(negedge hclk);
    `CHK("part rd", 14'h0a5c, rdata_out)
    @(posedge hclk);
    req <= {1'b1, 1'b0, 1'b1, CPIA_MEM_CFG, STEP_ADDR, 14'h0};
    @(negedge hclk);
    `CHK("id wr", 1'b0, gate.allow)
    @(posedge hclk);
    req <= {1'b1, 1'b0, 1'b1, CPIA_MEM_CFG, 16'h8002, 14'h2b7};
    @(posedge hclk);
    req.valid <= 1'b0;
    ahb(0, 8'h18, 0); `CHK("uid req", 14'h2b7, rv[13:0])
    conclude();
  end
endmodule
bind cpia_top cpia_props u_props (.hclk, .hresetn, .clk_en, .nv_guard_bits, .nv_range_sel, .req, .gate,
  .mem_rdata, .rdata_out, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata);
